// ===== ocl_option_config_regs.vh
`ifndef OCL_OPTION_CONFIG_REGS_VH
`define OCL_OPTION_CONFIG_REGS_VH

// Register indices on the plain register port
`define OCL_ADDR_W 4
`define OCL_REG_BOOT_PROT 4'h0
`define OCL_REG_IAP_BND 4'h1
`define OCL_REG_OSC 4'h2
`define OCL_REG_WDT_PRESET 4'h3
`define OCL_REG_ISP_CTRL 4'h4
`define OCL_REG_STATUS 4'h5
`define OCL_REG_WDT_CTRL 4'h6

// Erased option bytes read as all ones, the documented defaults
`define OCL_OPT_RESET 8'hff

// boot_and_protect_options fields
`define OCL_B_LV_FLASH_PROT 7
`define OCL_B_LV_RESET_EN 6
`define OCL_B_ISP_SEL_HI 5
`define OCL_B_ISP_SEL_LO 4
`define OCL_B_HW_BOOT_SEL 3
`define OCL_B_SCRAMBLE 1
`define OCL_B_LOCK 0

// iap_boundary_option field occupies bits 7:1
`define OCL_IAP_BND_HI 7
`define OCL_IAP_BND_LO 1
`define OCL_IAP_BND_NONE 7'h7f
`define OCL_IAP_BND_SHIFT 9'h000

// oscillator_options fields
`define OCL_B_XTAL_GAIN 6
`define OCL_B_RC_OSC 1

// watchdog_preset_options fields
`define OCL_B_HW_WDT_EN 5
`define OCL_B_HW_WDT_IDLE 3
`define OCL_WDT_PS_HI 2
`define OCL_WDT_PS_LO 0

// isp_control_register fields
`define OCL_B_SW_BOOT_SEL 6
`define OCL_B_SW_RESET 5

// watchdog_control_register image
`define OCL_WDT_ENABLE 8'h20
`define OCL_WDT_IDLE 8'h08
`define OCL_WDT_CLEAR 8'h00
`define OCL_WDT_DIV_BASE 9'h002

// ISP start codes and addresses
`define OCL_ISP_CODE_0 2'b00
`define OCL_ISP_CODE_1 2'b01
`define OCL_ISP_CODE_2 2'b10
`define OCL_ISP_START_0 16'h1400
`define OCL_ISP_START_1 16'h1800
`define OCL_ISP_START_2 16'h1c00

// RAM address bits: above the top, and upper half
`define OCL_B_RAM_OVER 8
`define OCL_B_RAM_UPPER 7

// Memory limits
`define OCL_FLASH_TOP 16'h1fff
`define OCL_FLASH_END 16'h2000

`endif

// ===== ocl_option_config_loader.v
// Notes on behaviour
// - Lower 128 RAM bytes, 00h to 7Fh, accept direct addressing.
// - Upper 128 RAM bytes, 80h to FFh, accept indirect addressing only.
// - RAM accesses above FFh are inhibited.
// - Every external data move is inhibited; no external memory exists.
// - Option bytes are read-only to software; writes are ignored.
// - Flash protect bit 0 blocks ISP/IAP flash access during low voltage.
// - Reset enable bit 0 asserts reset during low voltage.
// - ISP start field: 00=1400h, 01=1800h, 10=1C00h, 11=no ISP.
// - Power-up copies inverted hardware boot select into software select.
// - Pin or software boots keep software select; entrance follows it.
// - Scramble bit 0 scrambles programmer code dumps.
// - Lock bit 0 refuses programmer code dumps.
// - IAP region spans boundary times 512 up to ISP start; ones=none.
// - Application flash writes allowed only inside the IAP region.
// - RC bit 0 enables the RC oscillator as clock source.
// - Gain bit 0 reduces crystal amplifier gain.
// - Watchdog enable bit 0 enables and presets watchdog at power-up.
// - Idle bit: 0 suspends watchdog in idle, 1 keeps counting.
// - Prescale codes 000..111 divide watchdog clock by 2..256.
// - Program counter past 1FFFh halts all operation.
`timescale 1ns/1ps
`include "ocl_option_config_regs.vh"

module ocl_option_config_loader #(
  parameter [7:0] SCRAMBLE_KEY = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // Nonvolatile option bytes
  input wire [7:0] opt_boot_prot_in,
  input wire [7:0] opt_iap_bnd_in,
  input wire [7:0] opt_osc_in,
  input wire [7:0] opt_wdt_in,
  // Power and reset pins, asynchronous levels
  input wire power_up_in,
  input wire pin_reset_in,
  input wire low_voltage_in,
  // Register port
  input wire [`OCL_ADDR_W-1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // Core RAM and external move checks
  input wire ram_req_in,
  input wire [8:0] ram_addr_in,
  input wire ram_indirect_in,
  output reg ram_grant_out,
  output reg ram_deny_out,
  input wire ext_move_req_in,
  output reg ext_move_deny_out,
  // Program counter watch
  input wire [15:0] pc_in,
  output reg core_halt_out,
  // ISP/IAP flash access checks
  input wire flash_req_in,
  input wire [15:0] flash_addr_in,
  input wire flash_write_in,
  output reg flash_grant_out,
  output reg flash_deny_out,
  // Programmer code dump
  input wire dump_req_in,
  input wire [7:0] dump_addr_in,
  input wire [7:0] dump_data_in,
  output reg dump_valid_out,
  output reg [7:0] dump_data_out,
  output reg dump_refused_out,
  // Decoded configuration
  output reg boot_pulse_out,
  output reg boot_isp_out,
  output reg lv_reset_out,
  output reg rc_osc_en_out,
  output reg xtal_gain_low_out,
  output reg wdt_hw_en_out,
  output reg wdt_idle_run_out,
  output reg [7:0] wdt_ctrl_preset_out,
  output reg [8:0] wdt_divisor_out,
  output reg isp_present_out,
  output reg [15:0] isp_start_out,
  output reg iap_present_out,
  output reg [15:0] iap_low_out
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // Three-stage synchronisers; a level counts once stages 2 and 3 agree
  // One-cycle glitches on the pins are dropped by the agreement test
  localparam NUM_SYNC = 3;
  wire [NUM_SYNC-1:0] async_lvl = {low_voltage_in, pin_reset_in,
                                   power_up_in};
  wire [NUM_SYNC-1:0] sync_lvl;
  genvar g;

  generate
    for (g = 0; g < NUM_SYNC; g = g + 1) begin : g_sync
      reg [2:0] stage_q;
      reg level_q;

      always @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          stage_q <= 3'h0;
          level_q <= 1'b0;
        end else begin
          stage_q <= {stage_q[1:0], async_lvl[g]};
          if (stage_q[1] == stage_q[2]) begin
            level_q <= stage_q[2];
          end
        end
      end

      assign sync_lvl[g] = level_q;
    end
  endgenerate

  wire pup_q = sync_lvl[0];
  wire prst_q = sync_lvl[1];
  wire lv_q = sync_lvl[2];

  reg prst_d1_q;
  wire pin_boot = prst_d1_q & ~prst_q;
  wire soft_boot = reg_wr_in & (reg_addr_in == `OCL_REG_ISP_CTRL) &
                   reg_wdata_in[`OCL_B_SW_RESET];

  // Latched option bytes
  reg [2:0] state_q;
  reg [7:0] opt0_q;
  reg [7:0] opt1_q;
  reg [7:0] opt2_q;
  reg [7:0] opt3_q;
  reg sw_boot_sel_q;
  reg loaded_q;

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= ST_IDLE;
      opt0_q <= `OCL_OPT_RESET;
      opt1_q <= `OCL_OPT_RESET;
      opt2_q <= `OCL_OPT_RESET;
      opt3_q <= `OCL_OPT_RESET;
      sw_boot_sel_q <= 1'b0;
      loaded_q <= 1'b0;
      prst_d1_q <= 1'b0;
      boot_pulse_out <= 1'b0;
      boot_isp_out <= 1'b0;
    end else begin
      prst_d1_q <= prst_q;
      boot_pulse_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (pup_q) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Options are captured on every ST_LOAD cycle, including the one that sees power-up low
          opt0_q <= opt_boot_prot_in;
          opt1_q <= opt_iap_bnd_in;
          opt2_q <= opt_osc_in;
          opt3_q <= opt_wdt_in;
          if (!pup_q) begin
            state_q <= ST_RUN;
            loaded_q <= 1'b1;
            sw_boot_sel_q <= ~opt0_q[`OCL_B_HW_BOOT_SEL];
            boot_isp_out <= ~opt0_q[`OCL_B_HW_BOOT_SEL];
            boot_pulse_out <= 1'b1;
          end
        end
        ST_RUN: begin
          if (pup_q) begin
            state_q <= ST_LOAD;
          end else if (pin_boot | soft_boot) begin
            boot_isp_out <= sw_boot_sel_q;
            boot_pulse_out <= 1'b1;
          end else if (reg_wr_in &&
                       reg_addr_in == `OCL_REG_ISP_CTRL) begin
            sw_boot_sel_q <= reg_wdata_in[`OCL_B_SW_BOOT_SEL];
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Decoding
  wire [1:0] isp_sel = {opt0_q[`OCL_B_ISP_SEL_HI], opt0_q[`OCL_B_ISP_SEL_LO]};
  reg [15:0] isp_start_d;
  reg isp_present_d;

  always @* begin
    isp_present_d = 1'b1;
    case (isp_sel)
      `OCL_ISP_CODE_0: isp_start_d = `OCL_ISP_START_0;
      `OCL_ISP_CODE_1: isp_start_d = `OCL_ISP_START_1;
      `OCL_ISP_CODE_2: isp_start_d = `OCL_ISP_START_2;
      default: begin
        isp_start_d = `OCL_FLASH_END;
        isp_present_d = 1'b0;
      end
    endcase
  end

  wire [6:0] iap_bnd = opt1_q[`OCL_IAP_BND_HI:`OCL_IAP_BND_LO];
  wire [15:0] iap_low_d = {iap_bnd, `OCL_IAP_BND_SHIFT};
  // Without ISP code the region may reach the end of flash
  wire iap_present_d = (iap_bnd != `OCL_IAP_BND_NONE) &&
                       (iap_low_d < isp_start_d);
  wire in_iap = iap_present_d && (flash_addr_in >= iap_low_d) &&
                (flash_addr_in < isp_start_d);
  wire lv_block = ~opt0_q[`OCL_B_LV_FLASH_PROT] & lv_q;
  wire wdt_en = ~opt3_q[`OCL_B_HW_WDT_EN];
  wire [7:0] wdt_image = wdt_en ?
    (`OCL_WDT_ENABLE | (opt3_q[`OCL_B_HW_WDT_IDLE] ? `OCL_WDT_IDLE :
     `OCL_WDT_CLEAR) | {5'h00, opt3_q[`OCL_WDT_PS_HI:`OCL_WDT_PS_LO]}) :
    `OCL_WDT_CLEAR;
  wire flash_ok = ~lv_block && (flash_addr_in <= `OCL_FLASH_TOP) &&
                  (~flash_write_in | in_iap);
  wire ram_ok = ~ram_addr_in[`OCL_B_RAM_OVER] &
                (~ram_addr_in[`OCL_B_RAM_UPPER] |
                 ram_indirect_in);
  wire [7:0] status = {core_halt_out, lv_reset_out, lv_block, lv_q,
                       isp_present_out, iap_present_out, boot_isp_out,
                       loaded_q};

  // Registered outputs
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lv_reset_out <= 1'b0;
      rc_osc_en_out <= 1'b0;
      xtal_gain_low_out <= 1'b0;
      wdt_hw_en_out <= 1'b0;
      wdt_idle_run_out <= 1'b1;
      wdt_ctrl_preset_out <= `OCL_WDT_CLEAR;
      wdt_divisor_out <= `OCL_WDT_DIV_BASE;
      isp_present_out <= 1'b0;
      isp_start_out <= `OCL_FLASH_END;
      iap_present_out <= 1'b0;
      iap_low_out <= `OCL_FLASH_END;
      core_halt_out <= 1'b0;
    end else begin
      lv_reset_out <= ~opt0_q[`OCL_B_LV_RESET_EN] & lv_q;
      rc_osc_en_out <= ~opt2_q[`OCL_B_RC_OSC];
      xtal_gain_low_out <= ~opt2_q[`OCL_B_XTAL_GAIN];
      wdt_hw_en_out <= wdt_en;
      wdt_idle_run_out <= opt3_q[`OCL_B_HW_WDT_IDLE];
      wdt_ctrl_preset_out <= wdt_image;
      wdt_divisor_out <= `OCL_WDT_DIV_BASE <<
        opt3_q[`OCL_WDT_PS_HI:`OCL_WDT_PS_LO];
      isp_present_out <= isp_present_d;
      isp_start_out <= isp_start_d;
      iap_present_out <= iap_present_d;
      iap_low_out <= iap_low_d;
      core_halt_out <= (pc_in > `OCL_FLASH_TOP);
    end
  end

  // Access checks, answered one cycle after the request
  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ram_grant_out <= 1'b0;
      ram_deny_out <= 1'b0;
      ext_move_deny_out <= 1'b0;
      flash_grant_out <= 1'b0;
      flash_deny_out <= 1'b0;
      dump_valid_out <= 1'b0;
      dump_data_out <= 8'h00;
      dump_refused_out <= 1'b0;
    end else begin
      ram_grant_out <= ram_req_in & ram_ok;
      ram_deny_out <= ram_req_in & ~ram_ok;
      ext_move_deny_out <= ext_move_req_in;
      flash_grant_out <= flash_req_in & flash_ok;
      flash_deny_out <= flash_req_in & ~flash_ok;
      dump_valid_out <= dump_req_in & opt0_q[`OCL_B_LOCK];
      dump_refused_out <= dump_req_in & ~opt0_q[`OCL_B_LOCK];
      // Locked dumps never expose the data bus
      if (dump_req_in & opt0_q[`OCL_B_LOCK]) begin
        dump_data_out <= opt0_q[`OCL_B_SCRAMBLE] ? dump_data_in :
          (dump_data_in ^ SCRAMBLE_KEY ^ dump_addr_in);
      end else begin
        dump_data_out <= 8'h00;
      end
    end
  end

  // Register read port; writes to option bytes have no effect
  reg [7:0] rdata_d;

  always @* begin
    case (reg_addr_in)
      `OCL_REG_BOOT_PROT: rdata_d = opt0_q;
      `OCL_REG_IAP_BND: rdata_d = opt1_q;
      `OCL_REG_OSC: rdata_d = opt2_q;
      `OCL_REG_WDT_PRESET: rdata_d = opt3_q;
      `OCL_REG_ISP_CTRL: rdata_d = {1'b0, sw_boot_sel_q, 6'h00};
      `OCL_REG_STATUS: rdata_d = status;
      `OCL_REG_WDT_CTRL: rdata_d = wdt_ctrl_preset_out;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_d;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end

endmodule // ocl_option_config_loader

// ===== ocl_option_config_loader_sva.sv
`timescale 1ns/1ps
`include "ocl_option_config_regs.vh"
module ocl_option_config_loader_sva (
  // Clock and reset
  input wire mclk_in,
  input wire rstn_in,
  // Watched ports
  input wire [`OCL_ADDR_W-1:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire ram_req_in,
  input wire [8:0] ram_addr_in,
  input wire ram_indirect_in,
  input wire ram_grant_out,
  input wire ram_deny_out,
  input wire ext_move_req_in,
  input wire ext_move_deny_out,
  input wire [15:0] pc_in,
  input wire core_halt_out,
  input wire flash_req_in,
  input wire [15:0] flash_addr_in,
  input wire flash_grant_out,
  input wire flash_deny_out,
  input wire dump_req_in,
  input wire dump_valid_out,
  input wire dump_refused_out,
  input wire boot_pulse_out,
  input wire wdt_hw_en_out,
  input wire [7:0] wdt_ctrl_preset_out,
  input wire [8:0] wdt_divisor_out,
  input wire isp_present_out,
  input wire [15:0] isp_start_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_soft_boot;
    reg_wr_in && reg_addr_in == `OCL_REG_ISP_CTRL &&
      reg_wdata_in[`OCL_B_SW_RESET];
  endsequence
  sequence s_ram_upper;
    ram_req_in && ram_addr_in[8:7] == 2'b01;
  endsequence
  chk_ram_low_grant:
    assert property (ram_req_in && ram_addr_in[8:7] == 2'b00 |=> ram_grant_out)
    else $error("low ram access not granted");
  chk_ram_upper_mode:
    assert property (s_ram_upper |=> ram_grant_out == $past(ram_indirect_in)
      && ram_deny_out != ram_grant_out)
    else $error("upper ram grant does not follow addressing mode");
  chk_ram_over_deny:
    assert property (ram_req_in && ram_addr_in[8] |=> ram_deny_out)
    else $error("ram access above top not denied");
  chk_ext_move_deny:
    assert property (ext_move_req_in |=> ext_move_deny_out)
    else $error("external move not denied");
  chk_pc_halt_top:
    assert property (1'b1 |=> core_halt_out == ($past(pc_in) > 16'h1fff))
    else $error("halt does not follow program counter");
  chk_flash_one_answer:
    assert property (flash_req_in |=> flash_grant_out != flash_deny_out)
    else $error("flash request without single answer");
  chk_flash_top_deny:
    assert property (flash_req_in && flash_addr_in > 16'h1fff
      |=> flash_deny_out)
    else $error("flash access above top not denied");
  chk_dump_one_answer:
    assert property (dump_req_in |=> dump_valid_out != dump_refused_out)
    else $error("dump request without single answer");
  chk_soft_boot_pulse:
    assert property (s_soft_boot |=> boot_pulse_out)
    else $error("software boot gave no boot pulse");
  chk_wdt_divisor_code:
    assert property (wdt_hw_en_out |-> wdt_ctrl_preset_out[5] &&
      wdt_divisor_out == (9'h002 << wdt_ctrl_preset_out[2:0]))
    else $error("watchdog divisor does not match prescale");
  chk_isp_start_set:
    assert property (isp_present_out |-> isp_start_out == 16'h1400 ||
      isp_start_out == 16'h1800 || isp_start_out == 16'h1c00)
    else $error("isp start outside decoded set");
endmodule // ocl_option_config_loader_sva

bind ocl_option_config_loader ocl_option_config_loader_sva u_sva (.*);

// ===== ocl_opt_programmer.sv
`timescale 1ns/1ps
module ocl_opt_programmer (
  // Clock
  input wire mclk_in,
  // Option bytes and power-up level
  output logic [7:0] opt0_out,
  output logic [7:0] opt1_out,
  output logic [7:0] opt2_out,
  output logic [7:0] opt3_out,
  output logic power_up_out
);
  initial begin
    {opt0_out, opt1_out, opt2_out, opt3_out} = 32'hffffffff;
    power_up_out = 1'b0;
  end
  // Bytes change only while power-up is high, so the load sees them settled
  task automatic burn(input logic [7:0] b0, b1, b2, b3);
    @(posedge mclk_in);
    opt0_out <= b0 | 8'h04;
    opt1_out <= b1 | 8'h01;
    opt2_out <= b2 | 8'hbd;
    opt3_out <= b3 | 8'hd0;
    power_up_out <= 1'b1;
    repeat (4) @(posedge mclk_in);
    power_up_out <= 1'b0;
    repeat (12) @(posedge mclk_in);
  endtask
endmodule // ocl_opt_programmer

// ===== ocl_option_config_loader_tb.sv
`timescale 1ns/1ps
`include "ocl_option_config_regs.vh"
module ocl_option_config_loader_tb;
  localparam logic [7:0] KEY = 8'h3c;
  logic mclk_in = 1'b0, rstn_in = 1'b0;
  logic pin_reset_in = 1'b0, low_voltage_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00, dump_addr_in = 8'h00, dump_data_in = 8'h00;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, ram_req_in = 1'b0;
  logic ram_indirect_in = 1'b0, ext_move_req_in = 1'b0, dump_req_in = 1'b0;
  logic [8:0] ram_addr_in = 9'h000;
  logic [15:0] pc_in = 16'h0000, flash_addr_in = 16'h0000;
  logic flash_req_in = 1'b0, flash_write_in = 1'b0;
  wire [7:0] opt_boot_prot_in, opt_iap_bnd_in, opt_osc_in, opt_wdt_in;
  wire [7:0] reg_rdata_out, dump_data_out, wdt_ctrl_preset_out;
  wire power_up_in, ram_grant_out, ram_deny_out, ext_move_deny_out;
  wire core_halt_out, flash_grant_out, flash_deny_out, dump_valid_out;
  wire dump_refused_out, boot_pulse_out, boot_isp_out, lv_reset_out;
  wire rc_osc_en_out, xtal_gain_low_out, wdt_hw_en_out, wdt_idle_run_out;
  wire isp_present_out, iap_present_out;
  wire [8:0] wdt_divisor_out;
  wire [15:0] isp_start_out, iap_low_out;
  int num_errors = 0, cmp_count = 0;

  ocl_option_config_loader #(.SCRAMBLE_KEY(KEY)) dut (.*);
  ocl_opt_programmer prog (
    .mclk_in(mclk_in),
    .opt0_out(opt_boot_prot_in),
    .opt1_out(opt_iap_bnd_in),
    .opt2_out(opt_osc_in),
    .opt3_out(opt_wdt_in),
    .power_up_out(power_up_in)
  );

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 chk("reg_rdata_out", e, reg_rdata_out);
  endtask

  task automatic ram(logic [8:0] a, logic ind, logic g);
    @(posedge mclk_in);
    ram_req_in <= 1'b1;
    ram_addr_in <= a;
    ram_indirect_in <= ind;
    @(posedge mclk_in);
    ram_req_in <= 1'b0;
    #1 chk("ram_grant_out", g, ram_grant_out);
    chk("ram_deny_out", !g, ram_deny_out);
  endtask

  task automatic fl(logic [15:0] a, logic w, logic g);
    @(posedge mclk_in);
    flash_req_in <= 1'b1;
    flash_addr_in <= a;
    flash_write_in <= w;
    @(posedge mclk_in);
    flash_req_in <= 1'b0;
    #1 chk("flash_grant_out", g, flash_grant_out);
    chk("flash_deny_out", !g, flash_deny_out);
  endtask

  task automatic dmp(logic [7:0] a, logic [7:0] d, logic v, logic [7:0] e);
    @(posedge mclk_in);
    dump_req_in <= 1'b1;
    dump_addr_in <= a;
    dump_data_in <= d;
    @(posedge mclk_in);
    dump_req_in <= 1'b0;
    #1 chk("dump_valid_out", v, dump_valid_out);
    chk("dump_refused_out", !v, dump_refused_out);
    chk("dump_data_out", v ? e : 8'h00, dump_data_out);
  endtask

  // Boot pulse lags the pin by a few sync stages
  // Pin held four cycles: the input filter drops one-cycle pulses
  task automatic pin_boot(logic e);
    int i;
    @(posedge mclk_in) pin_reset_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    pin_reset_in <= 1'b0;
    for (i = 0; i < 20 && boot_pulse_out !== 1'b1; i++) @(posedge mclk_in) #1;
    chk("boot_pulse_out", 1, boot_pulse_out);
    chk("boot_isp_out", e, boot_isp_out);
  endtask

  initial begin
    #100000;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (20) @(posedge mclk_in);
    rstn_in <= 1'b1;
    prog.burn(8'hff, 8'hff, 8'hff, 8'hff);
    chk("rc_osc_en_out", 0, rc_osc_en_out);
    chk("xtal_gain_low_out", 0, xtal_gain_low_out);
    chk("boot_isp_out", 0, boot_isp_out);
    chk("lv_reset_out", 0, lv_reset_out);
    chk("wdt_hw_en_out", 0, wdt_hw_en_out);
    chk("wdt_ctrl_preset_out", 8'h00, wdt_ctrl_preset_out);
    chk("isp_present_out", 0, isp_present_out);
    chk("iap_present_out", 0, iap_present_out);
    $display("erased defaults done");
    prog.burn(8'h06, 8'h11, 8'hbd, 8'hd5);
    chk("isp_start_out", 16'h1400, isp_start_out);
    chk("iap_low_out", 16'h1000, iap_low_out);
    chk("iap_present_out", 1, iap_present_out);
    chk("rc_osc_en_out", 1, rc_osc_en_out);
    chk("xtal_gain_low_out", 1, xtal_gain_low_out);
    chk("wdt_ctrl_preset_out", 8'h25, wdt_ctrl_preset_out);
    chk("wdt_idle_run_out", 0, wdt_idle_run_out);
    chk("boot_isp_out", 1, boot_isp_out);
    rd(`OCL_REG_ISP_CTRL, 8'h40);
    rd(`OCL_REG_WDT_CTRL, 8'h25);
    rd(`OCL_REG_STATUS, 8'h0f);
    wr(`OCL_REG_BOOT_PROT, 8'h00);
    rd(`OCL_REG_BOOT_PROT, 8'h06);
    rd(`OCL_REG_IAP_BND, 8'h11);
    fl(16'h1000, 1, 1);
    fl(16'h13ff, 1, 1);
    fl(16'h0ffe, 1, 0);
    fl(16'h1400, 1, 0);
    fl(16'h2000, 0, 0);
    @(posedge mclk_in) low_voltage_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1 chk("lv_reset_out", 1, lv_reset_out);
    fl(16'h0100, 0, 0);
    @(posedge mclk_in) low_voltage_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    fl(16'h0100, 0, 1);
    dmp(8'h10, 8'h77, 0, 8'h00);
    pin_boot(1);
    wr(`OCL_REG_ISP_CTRL, 8'h00);
    pin_boot(0);
    wr(`OCL_REG_ISP_CTRL, 8'h40);
    wr(`OCL_REG_ISP_CTRL, 8'h20);
    #1 chk("boot_isp_out", 1, boot_isp_out);
    rd(`OCL_REG_ISP_CTRL, 8'h40);
    $display("protect and boot done");
    for (int i = 0; i < 8; i++) begin
      prog.burn({2'b11, i[1:0], 2'b11, i[2], 1'b1}, 8'hff, 8'hff,
        {5'b11011, i[2:0]});
      chk("isp_present_out", i[1:0] != 2'b11, isp_present_out);
      if (i[1:0] != 2'b11)
        chk("isp_start_out", 16'h1400 + {i[1:0], 10'h000},
          isp_start_out);
      chk("iap_present_out", 0, iap_present_out);
      chk("wdt_hw_en_out", 1, wdt_hw_en_out);
      chk("wdt_idle_run_out", 1, wdt_idle_run_out);
      chk("wdt_divisor_out", 9'h002 << i[2:0], wdt_divisor_out);
      dmp(8'ha5, 8'h0f, 1, i[2] ? 8'h0f : 8'h0f ^ KEY ^ 8'ha5);
    end
    $display("option decode done");
    // Erased protect and reset bits: low voltage must change nothing
    @(posedge mclk_in) low_voltage_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1 chk("lv_reset_out", 0, lv_reset_out);
    fl(16'h0100, 0, 1);
    @(posedge mclk_in) low_voltage_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    $display("low voltage defaults done");
    ram(9'h07f, 0, 1);
    ram(9'h080, 0, 0);
    ram(9'h0ff, 1, 1);
    ram(9'h100, 1, 0);
    @(posedge mclk_in) ext_move_req_in <= 1'b1;
    @(posedge mclk_in) ext_move_req_in <= 1'b0;
    #1 chk("ext_move_deny_out", 1, ext_move_deny_out);
    @(posedge mclk_in) pc_in <= 16'h1fff;
    @(posedge mclk_in) pc_in <= 16'h2000;
    #1 chk("core_halt_out", 0, core_halt_out);
    @(posedge mclk_in) #1 chk("core_halt_out", 1, core_halt_out);
    $display("memory limits done");
    end_sim();
  end
endmodule // ocl_option_config_loader_tb
